// ### rtl/acr_regs.sv
`timescale 1ns/100ps
module acr_regs #(
    parameter int ADDR_W = 6,
    parameter int ARG_W = 8,
    parameter bit HAS_START_HS = 1'b1
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // Accelerator core side
    output logic o_start_request,
    input wire acr_pkg::acr_core_stat_t i_core_stat,
    output logic [ARG_W-1:0] o_first_arg,
    output logic [ARG_W-1:0] o_second_arg,
    output logic [ARG_W-1:0] o_third_arg,
    input wire logic [ARG_W-1:0] i_third_result,
    input wire logic i_third_output_valid_flag,
    output logic o_irq
);

    // Refused at elaboration: fields sit in byte lane 0, offsets need six bits
    if (ADDR_W < 6 || ADDR_W > 32 || ARG_W < 1 || ARG_W > 8) begin : g_bad_param
        $error("acr_regs: unsupported ADDR_W or ARG_W");
    end

    // ****************************************
    // Bus handshake
    // ****************************************
    logic awready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic wr_fire;
    logic rd_fire;
    logic [5:0] wr_off;
    logic [5:0] rd_off;
    logic wr_hit;
    logic rd_hit;
    logic wr_lane0;

    // One write and one read in flight; the next waits for the response
    assign wr_fire = i_awvalid && i_wvalid && !awready_reg && !bvalid_reg;
    assign rd_fire = i_arvalid && !arready_reg && !rvalid_reg;
    assign wr_off = i_awaddr[5:0];
    assign rd_off = i_araddr[5:0];
    // Upper address bits must be zero for a hit
    assign wr_hit = ((i_awaddr >> 6) == '0) && (wr_off <= acr_pkg::OFF_LAST);
    assign rd_hit = ((i_araddr >> 6) == '0) && (rd_off <= acr_pkg::OFF_LAST);
    // Every field lives in byte lane 0
    assign wr_lane0 = wr_fire && wr_hit && i_wstrb[0];

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            awready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= acr_pkg::RESP_OKAY;
        end else begin
            awready_reg <= wr_fire;
            if (awready_reg) begin
                bvalid_reg <= 1'b1;
            end else if (i_bready) begin
                bvalid_reg <= 1'b0;
            end
            if (wr_fire) begin
                bresp_reg <= wr_hit ? acr_pkg::RESP_OKAY : acr_pkg::RESP_SLVERR;
            end
        end
    end

    // ****************************************
    // Control word and core handshake
    // ****************************************
    logic start_reg;
    logic done_reg;
    logic auto_restart_reg;
    logic ctrl_read;
    logic start_write;

    assign ctrl_read = rd_fire && rd_hit && (rd_off == acr_pkg::OFF_CONTROL);
    assign start_write = wr_lane0 && (wr_off == acr_pkg::OFF_CONTROL)
        && i_wdata[acr_pkg::BIT_START];

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            start_reg <= acr_pkg::RST_START;
        end else if (start_write) begin
            start_reg <= 1'b1;
        end else if (auto_restart_reg && i_core_stat.run_complete_flag) begin
            start_reg <= 1'b1;
        end else if (i_core_stat.input_ready_flag) begin
            // Accepted: one run only unless rerun is on
            start_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            done_reg <= acr_pkg::RST_DONE;
        end else if (i_core_stat.run_complete_flag) begin
            // A completion in the read cycle survives the read
            done_reg <= 1'b1;
        end else if (ctrl_read) begin
            done_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            auto_restart_reg <= acr_pkg::RST_AUTO_RESTART;
        end else if (wr_lane0 && wr_off == acr_pkg::OFF_CONTROL) begin
            auto_restart_reg <= i_wdata[acr_pkg::BIT_AUTO_RESTART];
        end
    end

    // ****************************************
    // Argument registers
    // ****************************************
    logic [ARG_W-1:0] first_arg_reg;
    logic [ARG_W-1:0] second_arg_reg;
    logic [ARG_W-1:0] third_arg_reg;
    logic [ARG_W-1:0] third_result_reg;
    logic out_valid_reg;
    logic valid_read;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            first_arg_reg <= acr_pkg::RST_ARG[ARG_W-1:0];
            second_arg_reg <= acr_pkg::RST_ARG[ARG_W-1:0];
            third_arg_reg <= acr_pkg::RST_ARG[ARG_W-1:0];
        end else if (wr_lane0) begin
            // Raw bit pattern, no conversion of any kind
            unique case (wr_off)
                acr_pkg::OFF_FIRST_INPUT_ARG: begin
                    first_arg_reg <= i_wdata[ARG_W-1:0];
                end
                acr_pkg::OFF_SECOND_INPUT_ARG: begin
                    second_arg_reg <= i_wdata[ARG_W-1:0];
                end
                acr_pkg::OFF_THIRD_INPUT_ARG: begin
                    third_arg_reg <= i_wdata[ARG_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    assign valid_read = rd_fire && rd_hit && (rd_off == acr_pkg::OFF_THIRD_OUTPUT_VALID);

    // Separate from the input copy so software never sees its own write
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            third_result_reg <= acr_pkg::RST_ARG[ARG_W-1:0];
        end else if (i_third_output_valid_flag) begin
            third_result_reg <= i_third_result;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            out_valid_reg <= acr_pkg::RST_OUT_VALID;
        end else if (i_third_output_valid_flag) begin
            out_valid_reg <= 1'b1;
        end else if (valid_read) begin
            out_valid_reg <= 1'b0;
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    logic global_en_reg;
    logic [1:0] irq_enable_reg;
    logic [1:0] irq_status_reg;
    logic irq_reg;
    logic ready_prev_reg;

    generate
        if (HAS_START_HS) begin : g_irq
            logic [1:0] irq_event;

            assign irq_event = {i_core_stat.input_ready_flag && !ready_prev_reg,
                i_core_stat.run_complete_flag};

            always_ff @(posedge i_core_clk or posedge i_rst) begin
                if (i_rst) begin
                    ready_prev_reg <= 1'b0;
                end else begin
                    ready_prev_reg <= i_core_stat.input_ready_flag;
                end
            end

            always_ff @(posedge i_core_clk or posedge i_rst) begin
                if (i_rst) begin
                    global_en_reg <= acr_pkg::RST_GLOBAL_EN;
                    irq_enable_reg <= acr_pkg::RST_IRQ_ENABLE;
                end else if (wr_lane0) begin
                    if (wr_off == acr_pkg::OFF_GLOBAL_IRQ_ENABLE) begin
                        global_en_reg <= i_wdata[acr_pkg::BIT_GLOBAL_EN];
                    end
                    if (wr_off == acr_pkg::OFF_IRQ_SOURCE_ENABLE) begin
                        irq_enable_reg <= i_wdata[1:0];
                    end
                end
            end

            // Event wins over a toggle that would clear it
            always_ff @(posedge i_core_clk or posedge i_rst) begin
                if (i_rst) begin
                    irq_status_reg <= acr_pkg::RST_IRQ_STATUS;
                end else if (wr_lane0 && wr_off == acr_pkg::OFF_IRQ_SOURCE_STATUS) begin
                    irq_status_reg <= (irq_status_reg ^ i_wdata[1:0]) | irq_event;
                end else begin
                    irq_status_reg <= irq_status_reg | irq_event;
                end
            end

            always_ff @(posedge i_core_clk or posedge i_rst) begin
                if (i_rst) begin
                    irq_reg <= 1'b0;
                end else begin
                    irq_reg <= global_en_reg && |(irq_status_reg & irq_enable_reg);
                end
            end
        end else begin : g_no_irq
            // No start handshake: nothing of the interrupt facility exists
            assign global_en_reg = 1'b0;
            assign irq_enable_reg = 2'h0;
            assign irq_status_reg = 2'h0;
            assign irq_reg = 1'b0;
            assign ready_prev_reg = 1'b0;
        end
    endgenerate

    // ****************************************
    // Read path
    // ****************************************
    logic [31:0] rd_word;

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (rd_off)
            acr_pkg::OFF_CONTROL: begin
                rd_word[acr_pkg::BIT_START] = start_reg;
                rd_word[acr_pkg::BIT_DONE] = done_reg;
                rd_word[acr_pkg::BIT_IDLE] = i_core_stat.idle_flag;
                rd_word[acr_pkg::BIT_READY] = i_core_stat.input_ready_flag;
                rd_word[acr_pkg::BIT_AUTO_RESTART] = auto_restart_reg;
            end
            acr_pkg::OFF_GLOBAL_IRQ_ENABLE: begin
                rd_word[acr_pkg::BIT_GLOBAL_EN] = global_en_reg;
            end
            acr_pkg::OFF_IRQ_SOURCE_ENABLE: begin
                rd_word[1:0] = irq_enable_reg;
            end
            acr_pkg::OFF_IRQ_SOURCE_STATUS: begin
                rd_word[1:0] = irq_status_reg;
            end
            acr_pkg::OFF_FIRST_INPUT_ARG: begin
                rd_word[ARG_W-1:0] = first_arg_reg;
            end
            acr_pkg::OFF_SECOND_INPUT_ARG: begin
                rd_word[ARG_W-1:0] = second_arg_reg;
            end
            acr_pkg::OFF_THIRD_INPUT_ARG: begin
                rd_word[ARG_W-1:0] = third_arg_reg;
            end
            acr_pkg::OFF_THIRD_OUTPUT_ARG: begin
                rd_word[ARG_W-1:0] = third_result_reg;
            end
            acr_pkg::OFF_THIRD_OUTPUT_VALID: begin
                rd_word[acr_pkg::BIT_OUT_VALID] = out_valid_reg;
            end
            default: begin
            end
        endcase
        if (!rd_hit) begin
            rd_word = 32'h0000_0000;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= acr_pkg::RESP_OKAY;
        end else begin
            arready_reg <= rd_fire;
            if (rd_fire) begin
                // Captured with the clear-on-read side effects
                rdata_reg <= rd_word;
                rresp_reg <= rd_hit ? acr_pkg::RESP_OKAY : acr_pkg::RESP_SLVERR;
            end
            if (arready_reg) begin
                rvalid_reg <= 1'b1;
            end else if (i_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    assign o_awready = awready_reg;
    assign o_wready = awready_reg;
    assign o_bvalid = bvalid_reg;
    assign o_bresp = bresp_reg;
    assign o_arready = arready_reg;
    assign o_rvalid = rvalid_reg;
    assign o_rdata = rdata_reg;
    assign o_rresp = rresp_reg;
    assign o_start_request = start_reg;
    assign o_first_arg = first_arg_reg;
    assign o_second_arg = second_arg_reg;
    assign o_third_arg = third_arg_reg;
    assign o_irq = irq_reg;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    start_write_sets_a: assert property (start_write |=> o_start_request)
        else $error("start write did not raise start");
    start_accept_a: assert property (o_start_request && i_core_stat.input_ready_flag
        && !start_write && !(auto_restart_reg && i_core_stat.run_complete_flag)
        |=> !o_start_request)
        else $error("start not cleared on acceptance");
    rerun_restart_a: assert property (auto_restart_reg && i_core_stat.run_complete_flag
        |=> o_start_request)
        else $error("rerun did not restart");
    done_clear_a: assert property (ctrl_read && !i_core_stat.run_complete_flag
        |=> !done_reg ##1 o_rvalid)
        else $error("done not cleared by read");
    irq_output_a: assert property (HAS_START_HS && global_en_reg
        && |(irq_status_reg & irq_enable_reg) |=> o_irq)
        else $error("irq missing while pending");
    irq_gated_a: assert property (!global_en_reg |=> !o_irq)
        else $error("irq high while globally disabled");
    status_toggle_a: assert property (HAS_START_HS && wr_lane0
        && wr_off == acr_pkg::OFF_IRQ_SOURCE_STATUS && i_wdata[0]
        && !i_core_stat.run_complete_flag
        |=> irq_status_reg[0] != $past(irq_status_reg[0]))
        else $error("status bit did not toggle");
    status_sticky_a: assert property (HAS_START_HS && i_core_stat.run_complete_flag
        |=> irq_status_reg[0])
        else $error("done event not recorded");
    valid_clear_a: assert property (valid_read && !i_third_output_valid_flag
        |=> !out_valid_reg)
        else $error("valid flag not cleared by read");
    result_capture_a: assert property (i_third_output_valid_flag
        |=> third_result_reg == $past(i_third_result) && out_valid_reg)
        else $error("result not captured");
    reserved_zero_a: assert property (rd_fire && (rd_off == acr_pkg::OFF_SPARE_ONE
        || rd_off == acr_pkg::OFF_SPARE_TWO || rd_off == acr_pkg::OFF_SPARE_THREE)
        |=> o_rdata == 32'h0000_0000)
        else $error("reserved word read nonzero");
    no_irq_build_a: assert property (!HAS_START_HS |-> !o_irq)
        else $error("irq without start handshake");

endmodule

// ### common/acr_pkg.sv
package acr_pkg;

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [5:0] OFF_CONTROL = 6'h00;
    localparam logic [5:0] OFF_GLOBAL_IRQ_ENABLE = 6'h04;
    localparam logic [5:0] OFF_IRQ_SOURCE_ENABLE = 6'h08;
    localparam logic [5:0] OFF_IRQ_SOURCE_STATUS = 6'h0c;
    localparam logic [5:0] OFF_FIRST_INPUT_ARG = 6'h10;
    localparam logic [5:0] OFF_SPARE_ONE = 6'h14;
    localparam logic [5:0] OFF_SECOND_INPUT_ARG = 6'h18;
    localparam logic [5:0] OFF_SPARE_TWO = 6'h1c;
    localparam logic [5:0] OFF_THIRD_INPUT_ARG = 6'h20;
    localparam logic [5:0] OFF_SPARE_THREE = 6'h24;
    localparam logic [5:0] OFF_THIRD_OUTPUT_ARG = 6'h28;
    localparam logic [5:0] OFF_THIRD_OUTPUT_VALID = 6'h2c;
    localparam logic [5:0] OFF_LAST = 6'h2c;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_START = 0;
    localparam int BIT_DONE = 1;
    localparam int BIT_IDLE = 2;
    localparam int BIT_READY = 3;
    localparam int BIT_AUTO_RESTART = 7;
    localparam int BIT_GLOBAL_EN = 0;
    localparam int BIT_SRC_DONE = 0;
    localparam int BIT_SRC_READY = 1;
    localparam int BIT_OUT_VALID = 0;
    localparam int NUM_IRQ_SOURCES = 2;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic RST_START = 1'b0;
    localparam logic RST_DONE = 1'b0;
    localparam logic RST_AUTO_RESTART = 1'b0;
    localparam logic RST_GLOBAL_EN = 1'b0;
    localparam logic [1:0] RST_IRQ_ENABLE = 2'h0;
    localparam logic [1:0] RST_IRQ_STATUS = 2'h0;
    localparam logic [7:0] RST_ARG = 8'h00;
    localparam logic RST_OUT_VALID = 1'b0;

    // ****************************************
    // Bus responses
    // ****************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic run_complete_flag;
        logic idle_flag;
        logic input_ready_flag;
    } acr_core_stat_t;

endpackage

// ### tb/acr_core_model.sv
`timescale 1ns/100ps
module acr_core_model (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_start_request,
    input wire logic [2:0] i_lat,
    input wire logic [7:0] i_first_arg,
    input wire logic [7:0] i_second_arg,
    input wire logic [7:0] i_third_arg,
    output acr_pkg::acr_core_stat_t o_core_stat,
    output logic [7:0] o_third_result,
    output logic o_third_output_valid_flag
);
    logic busy_reg;
    logic ready_reg;
    logic done_reg;
    logic [2:0] cnt_reg;
    logic [7:0] res_reg;
    // Result lines are not held between pulses, so show the inverse
    assign o_third_result = o_third_output_valid_flag ? res_reg : ~res_reg;
    assign o_core_stat = '{done_reg, !busy_reg, ready_reg};
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            busy_reg <= 1'b0;
            ready_reg <= 1'b0;
            done_reg <= 1'b0;
            cnt_reg <= 3'h0;
            res_reg <= 8'h00;
            o_third_output_valid_flag <= 1'b0;
        end else begin
            ready_reg <= 1'b0;
            done_reg <= 1'b0;
            o_third_output_valid_flag <= 1'b0;
            if (!busy_reg && i_start_request) begin
                busy_reg <= 1'b1;
                ready_reg <= 1'b1;
                cnt_reg <= i_lat;
                res_reg <= (i_first_arg ^ i_second_arg) + i_third_arg;
            end else if (busy_reg && cnt_reg == 3'h0) begin
                busy_reg <= 1'b0;
                done_reg <= 1'b1;
                o_third_output_valid_flag <= 1'b1;
            end else if (busy_reg) begin
                cnt_reg <= cnt_reg - 3'h1;
            end
        end
    end
endmodule

// ### tb/accel_ctrl_regs_tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error %s exp %h got %h", nm, e, g); end end
module accel_ctrl_regs_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [5:0] awaddr = 6'h00;
    logic [5:0] araddr = 6'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic [2:0] lat = 3'h0;
    logic awready, wready, bvalid, arready, rvalid, start, irq, vld;
    logic [1:0] bresp, rresp, rs, lr;
    logic [31:0] rdata, rv;
    logic [7:0] a0, a1, a2, res;
    logic [7:0] ea[3];
    acr_pkg::acr_core_stat_t stat;
    logic [31:0] seed = 32'h38d8;
    int n_mismatch = 0;
    int tests_run = 0;
    int n_runs = 0;
    int nb;
    acr_regs #(.ADDR_W(6), .ARG_W(8), .HAS_START_HS(1'b1)) dut (.i_core_clk(clk),
        .i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
        .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp),
        .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
        .i_rready(rready), .o_start_request(start), .i_core_stat(stat), .o_first_arg(a0),
        .o_second_arg(a1), .o_third_arg(a2), .i_third_result(res),
        .i_third_output_valid_flag(vld), .o_irq(irq));
    acr_core_model u_core (.i_core_clk(clk), .i_rst(rst), .i_start_request(start),
        .i_lat(lat), .i_first_arg(a0), .i_second_arg(a1), .i_third_arg(a2),
        .o_core_stat(stat), .o_third_result(res), .o_third_output_valid_flag(vld));
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        if (stat.run_complete_flag === 1'b1) begin
            n_runs++;
        end
    end
    // ****************************************
    // Reference model and bus tasks
    // ****************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [31:0] fres();
        return {24'h0, 8'((int'(ea[0] ^ ea[1]) + int'(ea[2])) % 256)};
    endfunction
    task automatic print_verdict;
        if (n_mismatch == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Bounded wait; sampled at the edge, before that edge's updates land
    task automatic wt(ref logic s);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (s !== 1'b1 && k < 50);
        if (s !== 1'b1) begin
            n_mismatch++;
            print_verdict();
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        wt(awready);
        `CHK("wready", 1'b1, wready)
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        wt(bvalid);
        lr = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        wt(arready);
        arvalid <= 1'b0;
        wt(rvalid);
        rv = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    task automatic rc(input logic [5:0] a, input logic [31:0] e);
        rd(a);
        `CHK($sformatf("rdata_%h", a), e, rv)
    endtask
    // Start one run with a random core latency, poll the valid flag
    task automatic run_one;
        int k;
        seed = xs(seed);
        lat <= seed[2:0];
        wr(6'h00, 32'h1, 4'h1);
        k = 0;
        do begin
            rd(6'h2c);
            k++;
        end while (rv !== 32'h1 && k < 30);
        `CHK("out_valid", 32'h1, rv)
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 12; i++) rc(6'(i * 4), i == 0 ? 32'h4 : 32'h0);
        rd(6'h30);
        `CHK("rresp", acr_pkg::RESP_SLVERR, rs)
        wr(6'h30, 32'hffffffff, 4'hf);
        `CHK("bresp", acr_pkg::RESP_SLVERR, lr)
        for (int i = 0; i < 3; i++) begin
            seed = xs(seed);
            ea[i] = seed[7:0];
            wr(6'(16 + 8 * i), seed, 4'hf);
            wr(6'(20 + 8 * i), seed, 4'hf);
            rc(6'(16 + 8 * i), {24'h0, ea[i]});
            rc(6'(20 + 8 * i), 32'h0);
        end
        `CHK("args", {ea[0], ea[1], ea[2]}, {a0, a1, a2})
        wr(6'h10, 32'h0, 4'h0);
        rc(6'h10, {24'h0, ea[0]});
        wr(6'h00, 32'hfffffffe, 4'hf);
        rc(6'h00, 32'h84);
        wr(6'h00, 32'h0, 4'hf);
        wr(6'h28, 32'hff, 4'hf);
        rc(6'h28, 32'h0);
        wr(6'h04, 32'hffffffff, 4'hf);
        wr(6'h08, 32'h3, 4'hf);
        rc(6'h04, 32'h1);
        rc(6'h08, 32'h3);
        nb = n_runs;
        run_one();
        rc(6'h28, fres());
        rc(6'h2c, 32'h0);
        rc(6'h00, 32'h6);
        rc(6'h00, 32'h4);
        repeat (30) @(posedge clk);
        `CHK("runs", nb + 1, n_runs)
        `CHK("irq", 1'b1, irq)
        rc(6'h0c, 32'h3);
        wr(6'h0c, 32'h1, 4'h1);
        rc(6'h0c, 32'h2);
        `CHK("irq", 1'b1, irq)
        wr(6'h0c, 32'h2, 4'h1);
        rc(6'h0c, 32'h0);
        `CHK("irq", 1'b0, irq)
        wr(6'h04, 32'h0, 4'hf);
        run_one();
        rc(6'h0c, 32'h3);
        `CHK("irq", 1'b0, irq)
        wr(6'h04, 32'h1, 4'hf);
        repeat (2) @(posedge clk);
        `CHK("irq", 1'b1, irq)
        wr(6'h08, 32'h0, 4'hf);
        repeat (2) @(posedge clk);
        `CHK("irq", 1'b0, irq)
        nb = n_runs;
        wr(6'h00, 32'h81, 4'hf);
        seed = xs(seed);
        ea[0] = seed[7:0];
        wr(6'h10, seed, 4'hf);
        repeat (80) @(posedge clk);
        `CHK("reruns", 1'b1, n_runs - nb > 3)
        rc(6'h28, fres());
        wr(6'h00, 32'h0, 4'hf);
        repeat (20) @(posedge clk);
        nb = n_runs;
        repeat (40) @(posedge clk);
        `CHK("stopped", nb, n_runs)
        print_verdict();
    end
endmodule
